// ### rtl/serial_flash_command_decoder.sv
// serial flash command decoder: pin sampling, opcode decode, phase tracking
`timescale 1ns/1ps
`include "sfcd_params.svh"
module serial_flash_command_decoder #(
    parameter int DUMMY_W = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic [3:0] i_dq,
    input wire logic i_dual_en,
    input wire logic i_quad_en,
    input wire logic [DUMMY_W-1:0] i_dummy_cfg,
    input wire logic [1:0] i_ext_addr,
    input wire logic i_wip,
    output logic o_cmd_valid,
    output logic [7:0] o_opcode,
    output logic [2:0] o_addr_bytes,
    output logic [4:0] o_dummy,
    output logic [8:0] o_data_limit,
    output logic o_data_phase,
    output logic o_exec,
    output logic o_refused,
    output logic o_sw_reset,
    output logic o_wel,
    output logic o_addr4,
    output logic o_deep_pd,
    output logic [1:0] o_top_seg,
    output logic [7:0] o_flag_status
);

    // the dummy count must fit the five-bit dummy output
    if (DUMMY_W < 1 || DUMMY_W > 4)
    begin : g_chk
        $error("DUMMY_W must be 1 to 4");
    end

    // three-ff chains on clock and select, two flops on data: stage 0 feeds only stage 1
    logic [2:0] sclk_s_q;
    logic [2:0] cs_s_q;
    logic [3:0] dq1_q;
    logic [3:0] dq2_q;
    sfcd_pkg::state_t st_q, st_d;
    sfcd_pkg::proto_t prt_q, prt_d;
    logic [5:0] cnt_q, cnt_d;
    logic [7:0] sr_q, sr_d;
    logic ok_q, ok_d;
    logic wr_q, wr_d;
    logic valid_q, valid_d;
    logic [7:0] op_q, op_d;
    logic [2:0] ab_q, ab_d;
    logic [4:0] dm_q, dm_d;
    logic [8:0] lim_q, lim_d;
    logic exec_q, exec_d;
    logic ref_q, ref_d;
    logic swr_q, swr_d;
    logic wel_q, wel_d;
    logic a4_q, a4_d;
    logic dpd_q, dpd_d;
    logic arm_q, arm_d;
    logic [1:0] seg_q, seg_d;
    logic [7:0] fsr_q, fsr_d;
    logic dph_q, dph_d;
    logic sclk_rise, cs_fall, frame_end;
    logic [7:0] sh_op;
    logic dec_ok;
    logic [2:0] dec_ab;
    logic [4:0] dec_dm;
    sfcd_pkg::dec_t dec;
    sfcd_pkg::proto_t cur_prt;

    // opcode shift by lane count
    function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] d,
                                            input sfcd_pkg::proto_t p);
        logic [7:0] r;
        unique case (p)
            sfcd_pkg::PR_EXT: r = {s[6:0], d[0]};
            sfcd_pkg::PR_DUAL: r = {s[5:0], d[1:0]};
            sfcd_pkg::PR_QUAD: r = {s[3:0], d};
            default: r = s;
        endcase
        return r;
    endfunction

    // clock edges needed for a number of bytes in a protocol
    function automatic logic [5:0] edges(input logic [2:0] b, input sfcd_pkg::proto_t p);
        return {b, 3'h0} >> p;
    endfunction

    // dummy clocks; a non-zero user setting overrides the configurable classes
    function automatic logic [4:0] dummy_of(input sfcd_pkg::dcls_t c,
                                            input sfcd_pkg::proto_t p,
                                            input logic [DUMMY_W-1:0] cfg);
        logic [4:0] v;
        logic q;
        q = (p == sfcd_pkg::PR_QUAD);
        unique case (c)
            sfcd_pkg::DC_NONE: v = 5'h00;
            sfcd_pkg::DC_FIX8: v = `DUM_SFDP;
            sfcd_pkg::DC_FAST: v = q ? `DUM_FAST_Q : `DUM_FAST;
            sfcd_pkg::DC_DTR: v = q ? `DUM_DTR_Q : `DUM_DTR;
            sfcd_pkg::DC_CFG8: v = `DUM_QIO_DTR;
            sfcd_pkg::DC_TEN: v = `DUM_TEN;
            default: v = 5'h00;
        endcase
        if (c != sfcd_pkg::DC_NONE && c != sfcd_pkg::DC_FIX8 && cfg != '0)
            v = 5'(cfg);
        return v;
    endfunction

    // opcode table; dual folds the fast read, DTR and program aliases, quad only fast read and program; quad can lengthen the dummy phase
    function automatic sfcd_pkg::dec_t decode(input logic [7:0] op,
                                              input sfcd_pkg::proto_t p);
        sfcd_pkg::dec_t r;
        r = '0;
        r.canon = op;
        if (p == sfcd_pkg::PR_DUAL)
        begin
            if (op == `OP_FRD || op == `OP_FRD_DO) r.canon = `OP_FRD_DIO;
            if (op == `OP_DTR || op == `OP_DTR_DO) r.canon = `OP_DTR_DIO;
            if (op == `OP_PP || op == `OP_PP_DI) r.canon = `OP_PP_DIO;
        end
        if (p == sfcd_pkg::PR_QUAD)
        begin
            if (op == `OP_FRD || op == `OP_FRD_QO) r.canon = `OP_FRD_QIO;
            if (op == `OP_PP || op == `OP_PP_QI) r.canon = `OP_PP_QIO;
        end
        // protocol mask: bit 0 extended, bit 1 dual, bit 2 quad
        case (r.canon)
            `OP_RD_ID_A, `OP_RD_ID_B, `OP_READ: r.ok = 3'h1;
            `OP_MIO_ID: r.ok = 3'h6;
            `OP_FRD_DO, `OP_FRD_DIO, `OP_DTR_DO, `OP_DTR_DIO, `OP_FRD4_DO, `OP_FRD4_DIO,
            `OP_PP_DI, `OP_PP_DIO: r.ok = 3'h3;
            `OP_FRD_QO, `OP_FRD_QIO, `OP_DTR_QO, `OP_DTR_QIO, `OP_FRD4_QO, `OP_FRD4_QIO,
            `OP_PP_QI, `OP_PP_QIO: r.ok = 3'h5;
            `OP_RST_EN, `OP_RST_MEM, `OP_SFDP, `OP_FRD, `OP_DTR, `OP_RD4, `OP_FRD4,
            `OP_WREN, `OP_WRDI, `OP_RD_SR, `OP_WR_SR, `OP_RD_LK, `OP_WR_LK, `OP_RD_FSR,
            `OP_CLR_FSR, `OP_RD_NVC, `OP_WR_NVC, `OP_RD_VC, `OP_WR_VC, `OP_RD_EVC,
            `OP_WR_EVC, `OP_RD_EAR, `OP_WR_EAR, `OP_PP, `OP_SSE, `OP_SE, `OP_DIE_E,
            `OP_RESUME, `OP_SUSPEND, `OP_OTP_RD, `OP_OTP_PG, `OP_EN4B, `OP_EX4B,
            `OP_DPD, `OP_RDPD: r.ok = 3'h7;
            default: r.ok = 3'h0;
        endcase
        // address and dummy shape
        case (r.canon)
            `OP_READ, `OP_PP, `OP_PP_DI, `OP_PP_DIO, `OP_PP_QI, `OP_PP_QIO, `OP_SSE,
            `OP_SE, `OP_DIE_E, `OP_RD_LK, `OP_WR_LK, `OP_OTP_PG:
                r.amode = sfcd_pkg::AM_VAR;
            `OP_FRD, `OP_FRD_DO, `OP_FRD_DIO, `OP_FRD_QO, `OP_FRD_QIO, `OP_OTP_RD:
            begin
                r.amode = sfcd_pkg::AM_VAR;
                r.dcls = sfcd_pkg::DC_FAST;
            end
            `OP_DTR, `OP_DTR_DO, `OP_DTR_DIO, `OP_DTR_QO:
            begin
                r.amode = sfcd_pkg::AM_VAR;
                r.dcls = sfcd_pkg::DC_DTR;
            end
            `OP_DTR_QIO:
            begin
                r.amode = sfcd_pkg::AM_VAR;
                r.dcls = sfcd_pkg::DC_CFG8;
            end
            `OP_FRD4, `OP_FRD4_DO, `OP_FRD4_DIO, `OP_FRD4_QO:
            begin
                r.amode = sfcd_pkg::AM_4;
                r.dcls = sfcd_pkg::DC_FAST;
            end
            `OP_FRD4_QIO:
            begin
                r.amode = sfcd_pkg::AM_4;
                r.dcls = sfcd_pkg::DC_TEN;
            end
            `OP_RD4: r.amode = sfcd_pkg::AM_4;
            `OP_SFDP:
            begin
                r.amode = sfcd_pkg::AM_3;
                r.dcls = sfcd_pkg::DC_FIX8;
            end
            default: r.amode = sfcd_pkg::AM_NONE;
        endcase
        // opcodes gated by the write enable latch
        case (r.canon)
            `OP_WR_SR, `OP_WR_LK, `OP_WR_NVC, `OP_WR_VC, `OP_WR_EVC, `OP_WR_EAR, `OP_PP,
            `OP_PP_DI, `OP_PP_DIO, `OP_PP_QI, `OP_PP_QIO, `OP_SSE, `OP_SE, `OP_DIE_E,
            `OP_RESUME, `OP_SUSPEND, `OP_OTP_PG, `OP_EN4B, `OP_EX4B:
                r.wel = 1'b1;
            default: r.wel = 1'b0;
        endcase
        // fixed data lengths; zero means none or open ended
        case (r.canon)
            `OP_RD_ID_A, `OP_RD_ID_B: r.lim = `LIM_ID;
            `OP_MIO_ID: r.lim = `LIM_MIO_ID;
            `OP_PP, `OP_PP_DI, `OP_PP_DIO, `OP_PP_QI, `OP_PP_QIO: r.lim = `LIM_PAGE;
            `OP_OTP_RD: r.lim = `LIM_OTP;
            `OP_WR_SR, `OP_WR_LK, `OP_WR_VC, `OP_WR_EVC, `OP_WR_EAR:
                r.lim = `LIM_ONE;
            `OP_RD_NVC, `OP_WR_NVC: r.lim = `LIM_TWO;
            default: r.lim = 9'h000;
        endcase
        return r;
    endfunction

    // pin synchronisers
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sclk_s_q <= 3'h0;
            cs_s_q <= 3'h7;
            dq1_q <= 4'h0;
            dq2_q <= 4'h0;
        end
        else if (i_ce)
        begin
            sclk_s_q <= {sclk_s_q[1:0], i_sclk};
            cs_s_q <= {cs_s_q[1:0], i_cs_n};
            dq1_q <= i_dq;
            dq2_q <= dq1_q;
        end
    end

    assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
    assign cs_fall = !cs_s_q[1] && cs_s_q[2];
    assign frame_end = cs_s_q[1] && !cs_s_q[2];
    assign cur_prt = i_quad_en ? sfcd_pkg::PR_QUAD :
                     (i_dual_en ? sfcd_pkg::PR_DUAL : sfcd_pkg::PR_EXT);
    assign sh_op = shift_in(sr_q, dq2_q, prt_q);
    assign dec = decode(sh_op, prt_q);
    // in deep power-down only the release opcode is heard
    assign dec_ok = dec.ok[prt_q] && (!dpd_q || dec.canon == `OP_RDPD);
    assign dec_ab = (dec.amode == sfcd_pkg::AM_4 ||
                     (dec.amode == sfcd_pkg::AM_VAR && a4_q)) ? 3'h4 :
                    (dec.amode == sfcd_pkg::AM_NONE ? 3'h0 : 3'h3);
    assign dec_dm = dummy_of(dec.dcls, prt_q, i_dummy_cfg);

    // frame sequencer and command execution
    always_comb
    begin
        st_d = st_q;
        prt_d = prt_q;
        cnt_d = cnt_q;
        sr_d = sr_q;
        ok_d = ok_q;
        wr_d = wr_q;
        op_d = op_q;
        ab_d = ab_q;
        dm_d = dm_q;
        lim_d = lim_q;
        valid_d = 1'b0;
        exec_d = 1'b0;
        ref_d = 1'b0;
        swr_d = 1'b0;
        wel_d = wel_q;
        a4_d = a4_q;
        dpd_d = dpd_q;
        arm_d = arm_q;
        if (frame_end)
        begin
            // only a frame whose phases all completed acts; partial ones drop
            if (st_q == sfcd_pkg::ST_DATA)
            begin
                if (wr_q && !wel_q)
                    ref_d = 1'b1;
                else
                begin
                    exec_d = 1'b1;
                    arm_d = (op_q == `OP_RST_EN);
                    if (wr_q)
                        wel_d = 1'b0;
                    case (op_q)
                        `OP_WREN: wel_d = 1'b1;
                        `OP_WRDI: wel_d = 1'b0;
                        `OP_EN4B: a4_d = 1'b1;
                        `OP_EX4B: a4_d = 1'b0;
                        `OP_DPD: dpd_d = 1'b1;
                        `OP_RDPD: dpd_d = 1'b0;
                        `OP_RST_MEM:
                        if (arm_q)
                        begin
                            swr_d = 1'b1;
                            wel_d = 1'b0;
                            a4_d = 1'b0;
                        end
                        default: ;
                    endcase
                end
            end
            else if (st_q == sfcd_pkg::ST_SKIP)
                ref_d = 1'b1;
            st_d = sfcd_pkg::ST_IDLE;
        end
        else if (cs_fall)
        begin
            st_d = sfcd_pkg::ST_OPC;
            prt_d = cur_prt;
            cnt_d = 6'h00;
            sr_d = 8'h00;
        end
        else if (sclk_rise)
        begin
            cnt_d = cnt_q + 6'h01;
            unique case (st_q)
                sfcd_pkg::ST_OPC:
                begin
                    sr_d = sh_op;
                    if (cnt_q == edges(3'h1, prt_q) - 6'h01)
                    begin
                        cnt_d = 6'h00;
                        valid_d = dec_ok;
                        ok_d = dec_ok;
                        wr_d = dec.wel;
                        op_d = dec.canon;
                        ab_d = dec_ab;
                        dm_d = dec_dm;
                        lim_d = dec.lim;
                        if (!dec_ok)
                            st_d = sfcd_pkg::ST_SKIP;
                        else if (dec_ab != 3'h0)
                            st_d = sfcd_pkg::ST_ADDR;
                        else if (dec_dm != 5'h00)
                            st_d = sfcd_pkg::ST_DUMMY;
                        else
                            st_d = sfcd_pkg::ST_DATA;
                    end
                end
                sfcd_pkg::ST_ADDR:
                if (cnt_q == edges(ab_q, prt_q) - 6'h01)
                begin
                    cnt_d = 6'h00;
                    st_d = (dm_q != 5'h00) ? sfcd_pkg::ST_DUMMY : sfcd_pkg::ST_DATA;
                end
                sfcd_pkg::ST_DUMMY:
                if (cnt_q == {1'b0, dm_q} - 6'h01)
                begin
                    cnt_d = 6'h00;
                    st_d = sfcd_pkg::ST_DATA;
                end
                sfcd_pkg::ST_IDLE, sfcd_pkg::ST_DATA, sfcd_pkg::ST_SKIP: cnt_d = cnt_q;
            endcase
        end
    end

    // status views: ready tracks write in progress, segment ignored in 4-byte mode
    always_comb
    begin
        fsr_d = 8'h00;
        fsr_d[`FSR_READY] = !i_wip;
        fsr_d[`FSR_ADDR4] = a4_q;
        seg_d = a4_q ? 2'h0 : i_ext_addr;
        dph_d = (st_d == sfcd_pkg::ST_DATA); // flopped so the port needs no decode
    end

    // state registers; the enable freezes everything, pulses included
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= sfcd_pkg::ST_IDLE;
            prt_q <= sfcd_pkg::PR_EXT;
            cnt_q <= 6'h00;
            sr_q <= 8'h00;
            ok_q <= 1'b0;
            wr_q <= 1'b0;
            valid_q <= 1'b0;
            op_q <= 8'h00;
            ab_q <= 3'h0;
            dm_q <= 5'h00;
            lim_q <= 9'h000;
            exec_q <= 1'b0;
            ref_q <= 1'b0;
            swr_q <= 1'b0;
            wel_q <= 1'b0;
            a4_q <= 1'b0;
            dpd_q <= 1'b0;
            arm_q <= 1'b0;
            seg_q <= 2'h0;
            fsr_q <= 8'h80;
            dph_q <= 1'b0;
        end
        else if (i_ce)
        begin
            st_q <= st_d;
            prt_q <= prt_d;
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            ok_q <= ok_d;
            wr_q <= wr_d;
            valid_q <= valid_d;
            op_q <= op_d;
            ab_q <= ab_d;
            dm_q <= dm_d;
            lim_q <= lim_d;
            exec_q <= exec_d;
            ref_q <= ref_d;
            swr_q <= swr_d;
            wel_q <= wel_d;
            a4_q <= a4_d;
            dpd_q <= dpd_d;
            arm_q <= arm_d;
            seg_q <= seg_d;
            fsr_q <= fsr_d;
            dph_q <= dph_d;
        end
    end

    assign o_cmd_valid = valid_q;
    assign o_opcode = op_q;
    assign o_addr_bytes = ab_q;
    assign o_dummy = dm_q;
    assign o_data_limit = lim_q;
    assign o_data_phase = dph_q;
    assign o_exec = exec_q;
    assign o_refused = ref_q;
    assign o_sw_reset = swr_q;
    assign o_wel = wel_q;
    assign o_addr4 = a4_q;
    assign o_deep_pd = dpd_q;
    assign o_top_seg = seg_q;
    assign o_flag_status = fsr_q;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst || !i_ce);
    sequence s_exec_op(logic [7:0] c);
        o_exec && o_opcode == c;
    endsequence
    sequence s_valid_op(logic [7:0] c);
        o_cmd_valid && o_opcode == c;
    endsequence

    AST_RST_ARM: assert property (s_exec_op(`OP_RST_EN) |-> arm_q)
        else $error("reset enable did not arm");
    AST_SW_RESET: assert property (o_sw_reset |-> s_exec_op(`OP_RST_MEM) ##0 !o_wel)
        else $error("software reset without reset memory");
    AST_ID_EXT: assert property (s_valid_op(`OP_RD_ID_B) |->
        prt_q == sfcd_pkg::PR_EXT && o_data_limit == 9'h014)
        else $error("id read outside extended protocol");
    AST_SFDP: assert property (s_valid_op(`OP_SFDP) |->
        o_addr_bytes == 3'h3 && o_dummy == 5'h08)
        else $error("discovery read shape wrong");
    AST_ALIAS_DUAL: assert property (o_cmd_valid && prt_q == sfcd_pkg::PR_DUAL |->
        o_opcode != `OP_FRD && o_opcode != `OP_DTR && o_opcode != `OP_PP)
        else $error("dual alias not applied");
    AST_ALIAS_QUAD: assert property (o_cmd_valid && prt_q == sfcd_pkg::PR_QUAD |->
        o_opcode != `OP_FRD && o_opcode != `OP_PP)
        else $error("quad alias not applied");
    AST_RD4: assert property (s_valid_op(`OP_RD4) |->
        o_addr_bytes == 3'h4 && o_dummy == 5'h00)
        else $error("four-byte read shape wrong");
    AST_WEL_SET: assert property (s_exec_op(`OP_WREN) |=> o_wel [*1] or !i_ce)
        else $error("write enable not latched");
    AST_REFUSE: assert property (o_refused && wr_q && ok_q |-> !o_wel && !o_exec)
        else $error("guarded command refused with latch set");
    AST_ADDR4: assert property (s_exec_op(`OP_EN4B) |-> o_addr4 ##1 o_flag_status[0])
        else $error("four-byte mode not entered");
    AST_DPD: assert property (s_exec_op(`OP_DPD) |-> o_deep_pd)
        else $error("deep power-down not entered");
    AST_READY: assert property (i_ce |=> o_flag_status[7] == !$past(i_wip))
        else $error("ready bit not inverse of busy");
    AST_SEG: assert property (o_addr4 && $past(o_addr4) |-> o_top_seg == 2'h0)
        else $error("segment used in four-byte mode");
    AST_FRAME: assert property (frame_end |=> st_q == sfcd_pkg::ST_IDLE)
        else $error("frame did not close on select rise");

endmodule

// ### rtl/sfcd_params.svh
// opcodes, dummy counts, data limits and flag bit positions for the command decoder
`ifndef SFCD_PARAMS_SVH
`define SFCD_PARAMS_SVH
`define OP_RST_EN 8'h66
`define OP_RST_MEM 8'h99
`define OP_RD_ID_A 8'h9E
`define OP_RD_ID_B 8'h9F
`define OP_MIO_ID 8'hAF
`define OP_SFDP 8'h5A
`define OP_READ 8'h03
`define OP_FRD 8'h0B
`define OP_FRD_DO 8'h3B
`define OP_FRD_DIO 8'hBB
`define OP_FRD_QO 8'h6B
`define OP_FRD_QIO 8'hEB
`define OP_DTR 8'h0D
`define OP_DTR_DO 8'h3D
`define OP_DTR_DIO 8'hDB
`define OP_DTR_QO 8'h6D
`define OP_DTR_QIO 8'hED
`define OP_RD4 8'h13
`define OP_FRD4 8'h0C
`define OP_FRD4_DO 8'h3C
`define OP_FRD4_DIO 8'hBC
`define OP_FRD4_QO 8'h6C
`define OP_FRD4_QIO 8'hEC
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RD_SR 8'h05
`define OP_WR_SR 8'h01
`define OP_RD_LK 8'hE8
`define OP_WR_LK 8'hE5
`define OP_RD_FSR 8'h70
`define OP_CLR_FSR 8'h50
`define OP_RD_NVC 8'hB5
`define OP_WR_NVC 8'hB1
`define OP_RD_VC 8'h85
`define OP_WR_VC 8'h81
`define OP_RD_EVC 8'h65
`define OP_WR_EVC 8'h61
`define OP_RD_EAR 8'hC8
`define OP_WR_EAR 8'hC5
`define OP_PP 8'h02
`define OP_PP_DI 8'hA2
`define OP_PP_DIO 8'hD2
`define OP_PP_QI 8'h32
`define OP_PP_QIO 8'h12
`define OP_SSE 8'h20
`define OP_SE 8'hD8
`define OP_DIE_E 8'hC4
`define OP_RESUME 8'h7A
`define OP_SUSPEND 8'h75
`define OP_OTP_RD 8'h4B
`define OP_OTP_PG 8'h42
`define OP_EN4B 8'hB7
`define OP_EX4B 8'hE9
`define OP_DPD 8'hB9
`define OP_RDPD 8'hA8
`define DUM_SFDP 5'h08
`define DUM_FAST 5'h08
`define DUM_FAST_Q 5'h0A
`define DUM_DTR 5'h06
`define DUM_DTR_Q 5'h08
`define DUM_QIO_DTR 5'h08
`define DUM_TEN 5'h0A
`define LIM_ID 9'h014
`define LIM_MIO_ID 9'h003
`define LIM_PAGE 9'h100
`define LIM_OTP 9'h040
`define LIM_ONE 9'h001
`define LIM_TWO 9'h002
`define FSR_READY 7
`define FSR_ADDR4 0
`endif

// ### rtl/sfcd_pkg.sv
// types shared by the serial flash command decoder
package sfcd_pkg;
    typedef enum logic [1:0] {PR_EXT, PR_DUAL, PR_QUAD} proto_t;
    typedef enum logic [1:0] {AM_NONE, AM_VAR, AM_3, AM_4} amode_t;
    typedef enum logic [2:0] {DC_NONE, DC_FIX8, DC_FAST, DC_DTR, DC_CFG8, DC_TEN} dcls_t;
    typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_SKIP} state_t;
    typedef struct packed {
        logic [2:0] ok;
        amode_t amode;
        dcls_t dcls;
        logic wel;
        logic [8:0] lim;
        logic [7:0] canon;
    } dec_t;
endpackage

// ### verif/serial_flash_command_decoder_bench.sv
// self-checking bench for the serial flash command decoder
`timescale 1ns/1ps
module serial_flash_command_decoder_bench;
    logic i_ref_clk = 1'h0;
    logic i_rst = 1'h1;
    logic i_dual_en = 1'h0;
    logic i_quad_en = 1'h0;
    logic i_wip = 1'h0;
    logic i_ce = 1'h1;
    logic dp;
    logic [3:0] i_dummy_cfg = 4'h0;
    logic [1:0] i_ext_addr = 2'h3;
    logic i_sclk, i_cs_n, o_cmd_valid, o_data_phase, o_exec, o_refused, o_sw_reset;
    logic o_wel, o_addr4, o_deep_pd;
    logic [3:0] i_dq;
    logic [7:0] o_opcode, o_flag_status;
    logic [2:0] o_addr_bytes;
    logic [4:0] o_dummy;
    logic [8:0] o_data_limit;
    logic [1:0] o_top_seg;
    int n_mismatch = 0, n_checks = 0, ne = 0, nr = 0, nv = 0, ns = 0, de, dr, dv, ds;
    always #4 i_ref_clk = ~i_ref_clk;
    serial_flash_command_decoder dut (.i_ref_clk, .i_rst, .i_ce, .i_sclk, .i_cs_n, .i_dq,
        .i_dual_en, .i_quad_en, .i_dummy_cfg, .i_ext_addr, .i_wip, .o_cmd_valid, .o_opcode,
        .o_addr_bytes, .o_dummy, .o_data_limit, .o_data_phase, .o_exec, .o_refused,
        .o_sw_reset, .o_wel, .o_addr4, .o_deep_pd, .o_top_seg, .o_flag_status);
    spi_host_model host (.i_ref_clk, .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_dq(i_dq));
    // pulse counters; frames compare deltas so a stuck pulse shows as a count error
    always @(posedge i_ref_clk)
    begin
        nv <= nv + (o_cmd_valid === 1'h1);
        ne <= ne + (o_exec === 1'h1);
        nr <= nr + (o_refused === 1'h1);
        ns <= ns + (o_sw_reset === 1'h1);
        // data phase as it stands when the opcode is accepted
        if (o_cmd_valid === 1'h1)
            dp <= o_data_phase;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // w is bits per edge: 1 extended, 2 dual, 4 quad
    task automatic run(input int w, input logic [7:0] op, input int n);
        int v0, e0, r0, s0;
        @(posedge i_ref_clk);
        i_dual_en <= (w == 2);
        i_quad_en <= (w == 4);
        {v0, e0, r0, s0} = {nv, ne, nr, ns};
        host.frame(op, w, n);
        {dv, de, dr, ds} = {nv - v0, ne - e0, nr - r0, ns - s0};
    endtask
    task automatic dec(int w, logic [7:0] op, logic [7:0] c, int a, int d, int l);
        run(w, op, 0);
        chk(dv, 1);
        chk(o_opcode, c);
        chk(o_addr_bytes, a);
        chk(o_dummy, d);
        chk(o_data_limit, l);
        chk(dp, a == 0 && d == 0);
    endtask
    task automatic t_decode();
        dec(1, 8'h03, 8'h03, 3, 0, 0);
        dec(1, 8'h0B, 8'h0B, 3, 8, 0);
        dec(4, 8'h0B, 8'hEB, 3, 10, 0);
        dec(2, 8'h3B, 8'hBB, 3, 8, 0);
        dec(2, 8'h02, 8'hD2, 3, 0, 256);
        dec(1, 8'h0D, 8'h0D, 3, 6, 0);
        dec(4, 8'h0D, 8'h0D, 3, 8, 0);
        dec(4, 8'hED, 8'hED, 3, 8, 0);
        dec(2, 8'h13, 8'h13, 4, 0, 0);
        dec(1, 8'hEC, 8'hEC, 4, 10, 0);
        dec(4, 8'h5A, 8'h5A, 3, 8, 0);
        dec(1, 8'h9F, 8'h9F, 0, 0, 20);
        dec(2, 8'hAF, 8'hAF, 0, 0, 3);
        dec(4, 8'h32, 8'h12, 3, 0, 256);
        dec(1, 8'h4B, 8'h4B, 3, 8, 64);
        dec(1, 8'hB1, 8'hB1, 0, 0, 2);
        i_dummy_cfg <= 4'h5;
        dec(1, 8'h6B, 8'h6B, 3, 5, 0);
        i_dummy_cfg <= 4'h0;
    endtask
    task automatic t_refuse();
        run(2, 8'h03, 0);
        chk(dv, 0);
        chk(dr, 1);
        run(4, 8'h9F, 0);
        chk(dv, 0);
        chk(dr, 1);
        // one dummy edge short drops the frame; the full count executes it
        run(4, 8'h5A, 13);
        chk(dv, 1);
        chk(de + dr, 0);
        run(4, 8'h5A, 14);
        chk(de, 1);
        chk(o_data_limit, 0);
    endtask
    task automatic t_wel();
        run(1, 8'h20, 24);
        chk(de, 0);
        chk(dr, 1);
        run(1, 8'h06, 0);
        chk(o_wel, 1);
        chk(de, 1);
        run(1, 8'h20, 24);
        chk(o_wel, 0);
        chk(de, 1);
        chk(dr, 0);
        run(1, 8'h06, 0);
        // a frame sent while the enable is low must leave no trace
        i_ce <= 1'h0;
        run(1, 8'h04, 0);
        i_ce <= 1'h1;
        repeat (4) @(posedge i_ref_clk);
        chk(o_wel, 1);
        chk(de, 0);
        run(1, 8'h04, 0);
        chk(o_wel, 0);
    endtask
    task automatic t_poll();
        i_wip <= 1'h1;
        run(1, 8'h70, 8);
        chk(o_flag_status, 8'h00);
        i_wip <= 1'h0;
        repeat (2) run(1, 8'h70, 8);
        chk(o_flag_status, 8'h80);
    endtask
    task automatic t_modes();
        run(1, 8'h06, 0);
        run(1, 8'hB7, 0);
        chk(o_addr4, 1);
        chk(o_flag_status, 8'h81);
        chk(o_top_seg, 0);
        dec(1, 8'h03, 8'h03, 4, 0, 0);
        run(4, 8'h66, 0);
        run(4, 8'h99, 0);
        chk(ds, 1);
        chk(o_addr4, 0);
        chk(o_top_seg, 3);
        run(1, 8'hB9, 0);
        run(1, 8'h06, 0);
        chk(o_deep_pd, 1);
        chk(dr, 1);
        run(1, 8'hA8, 0);
        chk(o_deep_pd, 0);
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_mismatch++;
        final_report();
    end
    initial
    begin
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'h0;
        repeat (3) @(posedge i_ref_clk);
        t_decode();
        t_refuse();
        t_wel();
        t_poll();
        t_modes();
        final_report();
    end
endmodule

// ### verif/spi_host_model.sv
// host side model that drives the decoder's serial pins
`timescale 1ns/1ps
module spi_host_model (
    input wire logic i_ref_clk,
    output logic o_sclk,
    output logic o_cs_n,
    output logic [3:0] o_dq
);
    initial
    begin
        o_sclk = 1'h0;
        o_cs_n = 1'h1;
        o_dq = 4'h0;
    end
    // 10 ref clocks per half makes the 160 ns link clock
    task automatic half();
        repeat (10) @(posedge i_ref_clk);
    endtask
    // opcode msb first, w bits per edge, then n edges with a toggling pattern
    task automatic frame(input logic [7:0] op, input int w, input int n);
        logic [7:0] s;
        s = op;
        o_cs_n <= 1'h0;
        for (int i = 0; i < 8 / w + n; i++)
        begin
            o_dq <= (i < 8 / w) ? 4'(s[7:4] >> (4 - w)) : ~o_dq;
            s = s << w;
            half();
            o_sclk <= 1'h1;
            half();
            o_sclk <= 1'h0;
        end
        half();
        o_cs_n <= 1'h1;
        o_dq <= ~o_dq;
        half();
    endtask
endmodule
